// ---- design/msse_exec.sv ----
// executor for far-operand subtract, nibble swap and conditional skip
//
// Summary of operation
// - skip_on_nonzero_far skips the next instruction when the byte is not zero.
// - every taken skip inserts one dummy cycle, so it lasts two cycles.
// - subtract_to_working_far puts working register minus byte in the register.
// - subtract_to_memory_far writes that difference back, register unchanged.
// - both subtracts clear borrow-inverse on negative, set it otherwise.
// - both subtracts update overflow, null, half, borrow, signed, chained flags.
// - nibble_exchange_in_place_far swaps byte nibbles and writes it back.
// - nibble_exchange_to_working_far loads the swapped byte into the register.
// - skip_on_null_far skips the next instruction when the byte is zero.
// - move_and_skip_on_null_far loads the byte and skips when it is zero.
`timescale 1ns/100ps
`include "msse_cfg.svh"

module msse_exec (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     op_valid,
    input  msse_pkg::msse_op_t            op_code,
    input  wire logic [`MSSE_BYTE_W-1:0]  mem_rdata,
    input  wire logic                     wr_load,
    input  wire logic [`MSSE_BYTE_W-1:0]  wr_load_data,
    output logic                          ready,
    output logic      [`MSSE_BYTE_W-1:0]  working_register,
    output msse_pkg::msse_flags_t         flags,
    output logic                          mem_we,
    output logic      [`MSSE_BYTE_W-1:0]  mem_wdata,
    output logic                          skip_next,
    output logic                          dummy_cycle
);

    msse_pkg::msse_core_t       s;
    msse_pkg::msse_core_t       next_s;
    logic                       issue;
    logic                       take_skip;
    logic [`MSSE_BYTE_W-1:0]    difference;
    msse_pkg::msse_flags_t      sub_flags;
    logic [`MSSE_BYTE_W-1:0]    swapped;

    msse_subtractor u_sub (
        .minuend    (s.working_register),
        .subtrahend (mem_rdata),
        .difference (difference),
        .flags      (sub_flags)
    );

    msse_skip_eval u_skip (
        .op        (op_code),
        .operand   (mem_rdata),
        .take_skip (take_skip)
    );

    // no new instruction is taken while the dummy cycle runs
    assign ready       = (s.state == msse_pkg::st_run);
    assign issue       = op_valid && ready;
    assign swapped     = {mem_rdata[`MSSE_NIB_LO], mem_rdata[`MSSE_NIB_HI]};
    assign working_register = s.working_register;
    assign flags       = s.flags;
    assign mem_we      = s.mem_we;
    assign mem_wdata   = s.mem_wdata;
    assign skip_next   = s.skip_next;
    assign dummy_cycle = (s.state == msse_pkg::st_dummy);

    always_comb begin
        next_s = s;
        next_s.mem_we = 1'b0;
        next_s.skip_next = 1'b0;
        unique case (s.state)
            msse_pkg::st_run: begin
                if (issue) begin
                    case (op_code)
                        msse_pkg::op_idle: begin
                            next_s.mem_we = 1'b0;
                        end
                        msse_pkg::subtract_to_working_far: begin
                            next_s.working_register = difference;
                            next_s.flags = sub_flags;
                        end
                        msse_pkg::subtract_to_memory_far: begin
                            next_s.mem_we = 1'b1;
                            next_s.mem_wdata = difference;
                            next_s.flags = sub_flags;
                        end
                        msse_pkg::nibble_exchange_in_place_far: begin
                            next_s.mem_we = 1'b1;
                            next_s.mem_wdata = swapped;
                        end
                        msse_pkg::nibble_exchange_to_working_far: begin
                            next_s.working_register = swapped;
                        end
                        msse_pkg::skip_on_nonzero_far: begin
                            next_s.skip_next = take_skip;
                        end
                        msse_pkg::skip_on_null_far: begin
                            next_s.skip_next = take_skip;
                        end
                        msse_pkg::move_and_skip_on_null_far: begin
                            // loads the register but touches no flag
                            next_s.working_register = mem_rdata;
                            next_s.skip_next = take_skip;
                        end
                    endcase
                    if (take_skip) begin
                        next_s.state = msse_pkg::st_dummy;
                        next_s.dummy_left = `MSSE_DUMMY_CYCLES;
                    end
                end else if (wr_load) begin
                    // core loads only between instructions, so no conflict
                    next_s.working_register = wr_load_data;
                end
            end
            msse_pkg::st_dummy: begin
                if (s.dummy_left <= `MSSE_DUMMY_CYCLES
                        && s.dummy_left > `MSSE_DUMMY_RESET) begin
                    next_s.dummy_left = s.dummy_left - 2'h1;
                end
                if (s.dummy_left <= 2'h1) begin
                    next_s.state = msse_pkg::st_run;
                end
            end
            default: begin
                next_s.state = msse_pkg::st_run;
                next_s.dummy_left = `MSSE_DUMMY_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s.state            <= msse_pkg::st_run;
            s.working_register <= `MSSE_WR_RESET;
            s.flags            <= `MSSE_FLAGS_RESET;
            s.mem_we           <= 1'b0;
            s.mem_wdata        <= `MSSE_ZERO_BYTE;
            s.skip_next        <= 1'b0;
            s.dummy_left       <= `MSSE_DUMMY_RESET;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_issue(msse_pkg::msse_op_t o);
        issue && op_code == o;
    endsequence

    sequence s_issue_sub;
        issue && (op_code == msse_pkg::subtract_to_working_far
               || op_code == msse_pkg::subtract_to_memory_far);
    endsequence

    sequence s_issue_noflag;
        issue && op_code != msse_pkg::subtract_to_working_far
              && op_code != msse_pkg::subtract_to_memory_far;
    endsequence

    sequence s_dummy_then_run;
        dummy_cycle && !ready ##1 ready && !dummy_cycle;
    endsequence

    skip_nonzero_a: assert property (
        s_issue(msse_pkg::skip_on_nonzero_far)
        |=> skip_next == ($past(mem_rdata) != `MSSE_ZERO_BYTE))
        else $error("nonzero skip decision wrong");

    skip_dummy_a: assert property (
        skip_next |-> s_dummy_then_run)
        else $error("taken skip did not insert exactly one dummy cycle");

    no_skip_run_a: assert property (
        issue && !take_skip |=> ready && !skip_next)
        else $error("untaken skip stalled the core");

    sub_work_a: assert property (
        s_issue(msse_pkg::subtract_to_working_far)
        |=> working_register
            == $past(working_register) - $past(mem_rdata) && !mem_we)
        else $error("register subtract result wrong");

    sub_mem_a: assert property (
        s_issue(msse_pkg::subtract_to_memory_far)
        |=> mem_we
            && mem_wdata == $past(working_register) - $past(mem_rdata)
            && working_register == $past(working_register)
        ##1 (!mem_we || $past(issue)))
        else $error("memory subtract write wrong");

    borrow_flag_a: assert property (
        s_issue_sub
        |=> flags.borrow_inverse_flag
            == ($past(working_register) >= $past(mem_rdata)))
        else $error("borrow-inverse flag wrong");

    sub_flags_a: assert property (
        s_issue_sub
        |=> flags.null_flag == ($past(working_register) == $past(mem_rdata))
            && flags.half_borrow_flag
               == ($past(working_register[`MSSE_NIB_LO])
                   >= $past(mem_rdata[`MSSE_NIB_LO]))
            && flags.carry_and_null_flag == flags.null_flag)
        else $error("subtract flags wrong");

    swap_mem_a: assert property (
        s_issue(msse_pkg::nibble_exchange_in_place_far)
        |=> mem_we && mem_wdata == {$past(mem_rdata[`MSSE_NIB_LO]),
                                    $past(mem_rdata[`MSSE_NIB_HI])})
        else $error("in-place nibble swap wrong");

    swap_work_a: assert property (
        s_issue(msse_pkg::nibble_exchange_to_working_far)
        |=> !mem_we && working_register[`MSSE_NIB_LO]
                       == $past(mem_rdata[`MSSE_NIB_HI])
            && working_register[`MSSE_NIB_HI]
               == $past(mem_rdata[`MSSE_NIB_LO]))
        else $error("register nibble swap wrong");

    skip_null_a: assert property (
        s_issue(msse_pkg::skip_on_null_far)
        |=> skip_next == ($past(mem_rdata) == `MSSE_ZERO_BYTE))
        else $error("zero skip decision wrong");

    move_skip_a: assert property (
        s_issue(msse_pkg::move_and_skip_on_null_far)
        |=> working_register == $past(mem_rdata)
            && skip_next == ($past(mem_rdata) == `MSSE_ZERO_BYTE))
        else $error("move and skip wrong");

    flags_hold_a: assert property (
        s_issue_noflag |=> $stable(flags))
        else $error("flags changed by swap or skip");

    // sign flags worked out from the signed operands, not from the adder
    sub_signed_a: assert property (
        s_issue_sub
        |=> flags.signed_carry_flag
            == ($signed($past(working_register)) < $signed($past(mem_rdata)))
            && flags.signed_range_exceeded_flag
               == (flags.signed_carry_flag
                   ^ (($past(working_register) - $past(mem_rdata)) >= 8'h80)))
        else $error("signed subtract flags wrong");

    // the write strobe follows only a memory-writing instruction
    sequence s_issue_mem_write;
        issue && (op_code == msse_pkg::subtract_to_memory_far
               || op_code == msse_pkg::nibble_exchange_in_place_far);
    endsequence

    sequence s_issue_skip;
        issue && (op_code == msse_pkg::skip_on_nonzero_far
               || op_code == msse_pkg::skip_on_null_far
               || op_code == msse_pkg::move_and_skip_on_null_far);
    endsequence

    mem_we_pulse_a: assert property (
        s_issue_mem_write |=> mem_we)
        else $error("memory write strobe missing");

    we_source_a: assert property (
        mem_we |-> $past(issue)
            && ($past(op_code) == msse_pkg::subtract_to_memory_far
             || $past(op_code) == msse_pkg::nibble_exchange_in_place_far))
        else $error("memory write without a writing instruction");

    // data bus is only ever changed together with the strobe
    wdata_hold_a: assert property (
        !mem_we |-> $stable(mem_wdata))
        else $error("write data moved without a write");

    skip_no_write_a: assert property (
        s_issue_skip |=> !mem_we && $stable(mem_wdata))
        else $error("skip instruction wrote memory");

    skip_source_a: assert property (
        skip_next |-> $past(issue)
            && ($past(op_code) == msse_pkg::skip_on_nonzero_far
             || $past(op_code) == msse_pkg::skip_on_null_far
             || $past(op_code) == msse_pkg::move_and_skip_on_null_far))
        else $error("skip without a skip instruction");

    dummy_skip_a: assert property (
        dummy_cycle |-> skip_next && !ready)
        else $error("dummy cycle without a skip");

    // nothing is taken or loaded while the dummy cycle runs
    dummy_hold_a: assert property (
        dummy_cycle
        |=> $stable(working_register) && $stable(flags) && !mem_we)
        else $error("state changed during the dummy cycle");

    wr_hold_a: assert property (
        !issue && !wr_load |=> $stable(working_register))
        else $error("working register changed with no cause");

    flags_quiet_a: assert property (
        !(issue && (op_code == msse_pkg::subtract_to_working_far
                 || op_code == msse_pkg::subtract_to_memory_far))
        |=> $stable(flags))
        else $error("flags changed without a subtract");

    idle_nop_a: assert property (
        s_issue(msse_pkg::op_idle)
        |=> ready && !mem_we && !skip_next && $stable(working_register))
        else $error("idle instruction had an effect");

    swap_keep_a: assert property (
        s_issue(msse_pkg::nibble_exchange_in_place_far)
        |=> $stable(working_register) && !skip_next)
        else $error("in-place swap touched the register");

endmodule

// ---- design/msse_skip_eval.sv ----
// decides whether a conditional-skip instruction skips its successor
`timescale 1ns/100ps
`include "msse_cfg.svh"

module msse_skip_eval (
    input  msse_pkg::msse_op_t          op,
    input  wire logic [`MSSE_BYTE_W-1:0] operand,
    output logic                         take_skip
);

    logic zero;

    always_comb begin
        zero = msse_pkg::byte_is_zero(operand);
        unique case (op)
            msse_pkg::skip_on_nonzero_far:       take_skip = ~zero;
            msse_pkg::skip_on_null_far:          take_skip = zero;
            msse_pkg::move_and_skip_on_null_far: take_skip = zero;
            default:                             take_skip = 1'b0;
        endcase
    end

endmodule

// ---- design/msse_subtractor.sv ----
// working register minus memory byte, with the six arithmetic flags
`timescale 1ns/100ps
`include "msse_cfg.svh"

module msse_subtractor (
    input  wire logic [`MSSE_BYTE_W-1:0] minuend,
    input  wire logic [`MSSE_BYTE_W-1:0] subtrahend,
    output logic      [`MSSE_BYTE_W-1:0] difference,
    output msse_pkg::msse_flags_t         flags
);

    logic [`MSSE_BYTE_W:0]  wide;
    logic [`MSSE_HALF_BIT:0] half;
    logic                    ov;
    logic                    zero;

    always_comb begin
        wide = {1'b0, minuend} - {1'b0, subtrahend};
        half = {1'b0, minuend[`MSSE_NIB_LO]} - {1'b0, subtrahend[`MSSE_NIB_LO]};
        difference = wide[`MSSE_BYTE_W-1:0];
        ov = (minuend[`MSSE_SIGN_BIT] ^ subtrahend[`MSSE_SIGN_BIT])
           & (minuend[`MSSE_SIGN_BIT] ^ difference[`MSSE_SIGN_BIT]);
        zero = msse_pkg::byte_is_zero(difference);
        flags.signed_range_exceeded_flag = ov;
        flags.null_flag                  = zero;
        flags.half_borrow_flag           = ~half[`MSSE_HALF_BIT];
        // borrow out of the top bit means a negative difference
        flags.borrow_inverse_flag        = ~wide[`MSSE_BYTE_W];
        // signed compare result: sign corrected by overflow
        flags.signed_carry_flag          = ov ^ difference[`MSSE_SIGN_BIT];
        // single-byte operation, so the chained zero equals the plain zero
        flags.carry_and_null_flag        = zero;
    end

endmodule

// ---- pkg/msse_cfg.svh ----
// constants for the far-operand subtract, swap and skip executor
`ifndef MSSE_CFG_SVH
`define MSSE_CFG_SVH

`define MSSE_BYTE_W          8
`define MSSE_NIB_HI          7:4
`define MSSE_NIB_LO          3:0
`define MSSE_SIGN_BIT        7
`define MSSE_HALF_BIT        4
`define MSSE_ZERO_BYTE       8'h00
`define MSSE_WR_RESET        8'h00
`define MSSE_FLAGS_RESET     6'h00
`define MSSE_DUMMY_CYCLES    2'h1
`define MSSE_DUMMY_RESET     2'h0

`endif

// ---- pkg/msse_pkg.sv ----
// types and shared decode for the far-operand subtract, swap and skip executor
`include "msse_cfg.svh"

package msse_pkg;

    typedef enum logic [2:0] {
        op_idle                        = 3'h0,
        subtract_to_working_far        = 3'h1,
        subtract_to_memory_far         = 3'h2,
        nibble_exchange_in_place_far   = 3'h3,
        nibble_exchange_to_working_far = 3'h4,
        skip_on_nonzero_far            = 3'h5,
        skip_on_null_far               = 3'h6,
        move_and_skip_on_null_far      = 3'h7
    } msse_op_t;

    typedef enum logic [1:0] {
        st_run   = 2'b01,
        st_dummy = 2'b10
    } msse_state_t;

    typedef struct packed {
        logic signed_range_exceeded_flag;
        logic null_flag;
        logic half_borrow_flag;
        logic borrow_inverse_flag;
        logic signed_carry_flag;
        logic carry_and_null_flag;
    } msse_flags_t;

    typedef struct packed {
        msse_state_t              state;
        logic [`MSSE_BYTE_W-1:0]  working_register;
        msse_flags_t              flags;
        logic                     mem_we;
        logic [`MSSE_BYTE_W-1:0]  mem_wdata;
        logic                     skip_next;
        logic [1:0]               dummy_left;
    } msse_core_t;

    function automatic logic byte_is_zero(input logic [`MSSE_BYTE_W-1:0] b);
        byte_is_zero = (b == `MSSE_ZERO_BYTE);
    endfunction

endpackage

// ---- testbench/tb_top.sv ----
// self-checking bench for the far-operand subtract, swap and skip executor
`timescale 1ns/100ps
`include "msse_cfg.svh"

module tb_top;
    logic                  clk;
    logic                  nrst;
    logic                  op_valid;
    msse_pkg::msse_op_t    op_code;
    logic [7:0]            mem_rdata;
    logic                  wr_load;
    logic [7:0]            wr_load_data;
    logic                  ready;
    logic [7:0]            working_register;
    msse_pkg::msse_flags_t flags;
    logic                  mem_we;
    logic [7:0]            mem_wdata;
    logic                  skip_next;
    logic                  dummy_cycle;
    int                    err_count;
    int                    samples_checked;
    logic [7:0]            sub_w [6];
    logic [7:0]            sub_m [6];
    logic [7:0]            skip_m [3];

    msse_exec i_dut (
        .clk              (clk),
        .nrst             (nrst),
        .op_valid         (op_valid),
        .op_code          (op_code),
        .mem_rdata        (mem_rdata),
        .wr_load          (wr_load),
        .wr_load_data     (wr_load_data),
        .ready            (ready),
        .working_register (working_register),
        .flags            (flags),
        .mem_we           (mem_we),
        .mem_wdata        (mem_wdata),
        .skip_next        (skip_next),
        .dummy_cycle      (dummy_cycle)
    );

    always #2.5 clk = ~clk;

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_sim();
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // flag image {ov, null, half, borrow_inv, signed, chained}, as packed
    function automatic logic [7:0] sub_flags(input logic [7:0] w,
                                             input logic [7:0] m);
        logic [7:0] d;
        logic       ov;
        d  = w - m;
        ov = (w[7] ^ m[7]) & (d[7] ^ w[7]);
        return {2'h0, ov, d == 8'h00, w[3:0] >= m[3:0], w >= m, ov ^ d[7],
                d == 8'h00};
    endfunction

    task automatic load_w(input logic [7:0] d);
        @(posedge clk);
        wr_load      <= 1'b1;
        wr_load_data <= d;
        @(posedge clk);
        wr_load <= 1'b0;
        #1;
        chk("loaded w", d, working_register);
    endtask

    // drive at an edge, let the next edge take it, look just after it
    task automatic issue(input msse_pkg::msse_op_t op, input logic [7:0] m);
        @(posedge clk);
        op_valid  <= 1'b1;
        op_code   <= op;
        mem_rdata <= m;
        @(posedge clk);
        op_valid <= 1'b0;
        op_code  <= msse_pkg::op_idle;
        #1;
    endtask

    task automatic t_subtract(input logic [7:0] w, input logic [7:0] m);
        load_w(w);
        issue(msse_pkg::subtract_to_working_far, m);
        chk("sub_w result", 8'(w - m), working_register);
        chk("sub_w flags", sub_flags(w, m), {2'h0, flags});
        chk("sub_w mem_we", 8'h00, {7'h0, mem_we});
        load_w(w);
        issue(msse_pkg::subtract_to_memory_far, m);
        chk("sub_m data", 8'(w - m), mem_wdata);
        chk("sub_m mem_we", 8'h01, {7'h0, mem_we});
        chk("sub_m keep w", w, working_register);
        chk("sub_m flags", sub_flags(w, m), {2'h0, flags});
    endtask

    task automatic t_swap();
        logic [7:0] f;
        load_w(8'h10);
        issue(msse_pkg::subtract_to_working_far, 8'h20);
        f = {2'h0, flags};
        issue(msse_pkg::nibble_exchange_in_place_far, 8'ha5);
        chk("swap data", 8'h5a, mem_wdata);
        chk("swap mem_we", 8'h01, {7'h0, mem_we});
        chk("swap keep w", 8'hf0, working_register);
        chk("swap flags", f, {2'h0, flags});
        @(posedge clk);
        #1;
        chk("swap we pulse", 8'h00, {7'h0, mem_we});
        issue(msse_pkg::nibble_exchange_to_working_far, 8'h3c);
        chk("swapa w", 8'hc3, working_register);
        chk("swapa mem_we", 8'h00, {7'h0, mem_we});
        chk("swapa flags", f, {2'h0, flags});
        issue(msse_pkg::op_idle, 8'h00);
        chk("idle", 8'h04, {5'h0, ready, skip_next, dummy_cycle});
    endtask

    // flags are made non-zero first so an unwanted update shows
    task automatic t_skip(input msse_pkg::msse_op_t op, input logic [7:0] m,
                          input logic sk);
        logic [7:0] f;
        logic [7:0] w;
        load_w(8'h7f);
        issue(msse_pkg::subtract_to_working_far, 8'h80);
        f = {2'h0, flags};
        w = (op == msse_pkg::move_and_skip_on_null_far) ? m : 8'hff;
        issue(op, m);
        chk("skip pulse", {7'h0, sk}, {7'h0, skip_next});
        chk("dummy cycle", {7'h0, sk}, {7'h0, dummy_cycle});
        chk("ready", {7'h0, ~sk}, {7'h0, ready});
        chk("skip w", w, working_register);
        chk("skip flags", f, {2'h0, flags});
        @(posedge clk);
        #1;
        chk("skip end", 8'h04, {5'h0, ready, skip_next, dummy_cycle});
    endtask

    // op and a register load held during the dummy cycle are not taken
    task automatic t_refuse();
        load_w(8'h11);
        @(posedge clk);
        op_valid  <= 1'b1;
        op_code   <= msse_pkg::skip_on_null_far;
        mem_rdata <= 8'h00;
        @(posedge clk);
        op_code      <= msse_pkg::nibble_exchange_to_working_far;
        mem_rdata    <= 8'h3c;
        wr_load      <= 1'b1;
        wr_load_data <= 8'h99;
        #1;
        chk("refuse dummy", 8'h01, {7'h0, dummy_cycle});
        @(posedge clk);
        wr_load <= 1'b0;
        #1;
        chk("refused op", 8'h11, working_register);
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("retried op", 8'hc3, working_register);
    endtask

    // two writes in adjacent cycles: both are taken, no gap is forced
    task automatic t_back_to_back();
        load_w(8'h40);
        @(posedge clk);
        op_valid  <= 1'b1;
        op_code   <= msse_pkg::subtract_to_memory_far;
        mem_rdata <= 8'h10;
        @(posedge clk);
        op_code   <= msse_pkg::nibble_exchange_in_place_far;
        mem_rdata <= 8'h12;
        #1;
        chk("b2b first", 8'h30, mem_wdata);
        @(posedge clk);
        op_valid <= 1'b0;
        op_code  <= msse_pkg::op_idle;
        #1;
        chk("b2b second", 8'h21, mem_wdata);
        chk("b2b mem_we", 8'h01, {7'h0, mem_we});
    endtask

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        op_valid = 1'b0;
        op_code = msse_pkg::op_idle;
        mem_rdata = 8'h00;
        wr_load = 1'b0;
        wr_load_data = 8'h00;
        err_count = 0;
        samples_checked = 0;
        sub_w = '{8'h50, 8'h20, 8'h80, 8'h7f, 8'h33, 8'h0f};
        sub_m = '{8'h20, 8'h50, 8'h01, 8'hff, 8'h33, 8'h10};
        skip_m = '{8'h00, 8'h01, 8'h80};
        repeat (11) @(posedge clk);
        #1;
        chk("reset w", 8'h00, working_register);
        chk("reset flags", 8'h00, {2'h0, flags});
        chk("reset outs", 8'h08, {4'h0, ready, mem_we, skip_next, dummy_cycle});
        @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            t_subtract(sub_w[i], sub_m[i]);
        end
        t_swap();
        t_back_to_back();
        for (int i = 0; i < 3; i++) begin
            t_skip(msse_pkg::skip_on_nonzero_far, skip_m[i],
                   skip_m[i] != 8'h00);
            t_skip(msse_pkg::skip_on_null_far, skip_m[i],
                   skip_m[i] == 8'h00);
            t_skip(msse_pkg::move_and_skip_on_null_far, skip_m[i],
                   skip_m[i] == 8'h00);
        end
        t_refuse();
        end_sim();
    end

    // the whole sequence needs about a hundred and fifty cycles
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        end_sim();
    end
endmodule
